/* File: verilog/cswu_map.svh */
// constants of the chip-select and wait-state unit: field positions, reset values, counts
// assumes inclusion by bare name from the unit
`ifndef CSWU_MAP_SVH
`define CSWU_MAP_SVH
`define CSWU_READY_BIT     2
`define CSWU_EXTWAIT_BIT   3
`define CSWU_UPPER_RST     7'h07
`define CSWU_LOWER_RST     7'h00
`define CSWU_MID_RST       10'h000
`define CSWU_PBASE_RST     13'h0000
`define CSWU_MPS_RST       8'h00
`define CSWU_XWAIT_0       4'h5
`define CSWU_XWAIT_1       4'h7
`define CSWU_XWAIT_2       4'h9
`define CSWU_XWAIT_3       4'hf
`define CSWU_POST_READY    4'h2
`define CSWU_BASE_CYCLES   4'h3
`define CSWU_PERIPH_BLOCKS 7
`define CSWU_MID_SELECTS   4
`endif

/* File: verilog/cswu_pkg.sv */
// types of the chip-select and wait-state unit
// assumes cswu_map.svh for widths of the reset constants
package cswu_pkg;
	typedef struct packed {
		logic [2:0] sizeLog;
		logic       addressDriveDisable;
		logic       extReadyRequired;
		logic [1:0] waitCount;
	} cswu_mem_ctrl_s;
	typedef struct packed {
		logic [6:0] base;
		logic       extReadyRequired;
		logic [1:0] waitCount;
	} cswu_mid_ctrl_s;
	typedef struct packed {
		logic [8:0] base;
		logic       extendedWait;
		logic       extReadyRequired;
		logic [1:0] waitCount;
	} cswu_pbase_ctrl_s;
	typedef struct packed {
		logic [2:0] midSizeLog;
		logic       ioSpace;
		logic       latchedAddress;
		logic       extReadyRequired;
		logic [1:0] waitCount;
	} cswu_mps_ctrl_s;
	typedef struct packed {
		logic [19:0] addr;
		logic        ioSpace;
		logic        fromDma;
	} cswu_cycle_s;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_T1   = 6'h02,
		ST_T2   = 6'h04,
		ST_T3   = 6'h08,
		ST_TW   = 6'h10,
		ST_T4   = 6'h20
	} cswu_state_e;
endpackage

/* File: verilog/cswu_unit.sv */
// chip-select and ready/wait-state unit of the external bus
// assumes: bus cycles offered by the cpu or dma on clk_sys; ready pins asynchronous
//
// Function
// - six memory selects over three ranges, seven peripheral 256-byte blocks from a base
// - selects assert for cpu and dma cycles inside their region
// - a lower, mid or peripheral-base control write enables that select's decode, whatever the pin function
// - upper and lower selects assert with the non-multiplexed address
// - either ready input may terminate a cycle
// - bit 2 chooses whether external ready is required
// - bits 1-0 give zero to three wait states
// - low peripheral selects: bit 3 with bits 1-0 gives 5, 7, 9, 15 waits
// - programmed waits finish before ready ends a cycle; a stretch at the first wait drops those left
// - ready sampled at first wait; if high, access is four plus waits
// - ready low at first wait: stretch until ready, two more waits, then t4
// - asynchronous ready active high, synchronised to the clock
// - peripheral selects in i/o space never overlap memory selects
// - on-chip block access: zero waits and no external ready, unless an overlapping select asks for more
// - address-disable on upper or lower hit suppresses multiplexed address drive
// - selects used as pio keep their ready and wait settings
// - unbonded fifth peripheral select keeps ready and wait logic
// - top two peripheral selects as latched a2/a1 lose ready and wait logic
// - first fetch after reset hits upper select with three waits
// - upper select resets to top 64K, ready required, three waits
// - lower and peripheral selects inactive until programmed
`include "cswu_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cswu_unit (
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,
	input  wire logic                      cycleReq,
	input  wire cswu_pkg::cswu_cycle_s     cycleIn,
	output logic                           cycleAccept,
	output logic                           cycleDone,
	output logic                           waitActive,
	input  wire logic                      asyncReady,
	input  wire logic                      syncReady,
	input  wire logic                      onchipHit,
	input  wire logic                      upperWr,
	input  wire cswu_pkg::cswu_mem_ctrl_s  upperCtrlIn,
	input  wire logic                      lowerWr,
	input  wire cswu_pkg::cswu_mem_ctrl_s  lowerCtrlIn,
	input  wire logic                      midWr,
	input  wire cswu_pkg::cswu_mid_ctrl_s  midCtrlIn,
	input  wire logic                      pbaseWr,
	input  wire cswu_pkg::cswu_pbase_ctrl_s pbaseCtrlIn,
	input  wire logic                      mpsWr,
	input  wire cswu_pkg::cswu_mps_ctrl_s  mpsCtrlIn,
	output cswu_pkg::cswu_state_e          busState,
	output logic                           addressDriveDisable,
	output logic                           upperSelect_n,
	output logic                           lowerSelect_n,
	output logic [3:0]                     midSelect_n,
	output logic [3:0]                     periphSelectLow_n,
	output logic                           periphSelectNext_n,
	output logic                           periphSelectTop_n
);
	localparam int NSRC = 14;
	localparam int SRC_MID = 2;
	localparam int SRC_PER = 6;
	localparam int SRC_PCB = 13;

	cswu_pkg::cswu_mem_ctrl_s   upperCtrl_q;
	cswu_pkg::cswu_mem_ctrl_s   lowerCtrl_q;
	cswu_pkg::cswu_mid_ctrl_s   midCtrl_q;
	cswu_pkg::cswu_pbase_ctrl_s pbaseCtrl_q;
	cswu_pkg::cswu_mps_ctrl_s   mpsCtrl_q;
	cswu_pkg::cswu_state_e      state_q;
	cswu_pkg::cswu_state_e      state_d;
	logic                       lowerEn_q;
	logic                       midEn_q;
	logic                       periphEn_q;
	logic                       upperWritten_q;
	logic                       ardyMeta_q;
	logic                       ardySync_q;
	logic                       srdyMeta_q;
	logic                       srdySync_q;
	logic                       readyNow;
	logic [NSRC-1:0]            hit;
	logic [NSRC-1:0]            hit_q;
	logic [3:0]                 srcWait [NSRC];
	logic                       srcRdy [NSRC];
	logic                       needRdyD;
	logic [3:0]                 waitsD;
	logic                       needRdy_q;
	logic [3:0]                 waits_q;
	logic [3:0]                 cnt_q;
	logic                       first_q;
	logic                       pend_q;
	logic                       stretched_q;
	logic [4:0]                 cycCnt_q;
	logic                       midHit;
	logic                       perHit;
	logic [1:0]                 midIdx;
	logic [2:0]                 perIdx;
	logic [6:0]                 midMask;
	logic [19:0]                midShift;
	logic                       startCycle;
	logic                       waitsDone;
	logic                       addrDisD;

	function automatic logic regionHit(input logic [3:0] a, input logic [2:0] sz,
		input logic top);
		logic [3:0] m;
		m = 4'hf << sz;
		regionHit = top ? ((a & m) == m) : ((a & m) == 4'h0);
	endfunction

	function automatic logic [3:0] waitDecode(input logic ext, input logic [1:0] w);
		logic [3:0] x;
		case (w)
			2'h0: x = `CSWU_XWAIT_0;
			2'h1: x = `CSWU_XWAIT_1;
			2'h2: x = `CSWU_XWAIT_2;
			default: x = `CSWU_XWAIT_3;
		endcase
		waitDecode = ext ? x : {2'h0, w};
	endfunction

	// both ready pins come from outside the clock domain
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ardyMeta_q <= 1'b0;
			ardySync_q <= 1'b0;
			srdyMeta_q <= 1'b0;
			srdySync_q <= 1'b0;
		end else begin
			ardyMeta_q <= asyncReady;
			ardySync_q <= ardyMeta_q;
			srdyMeta_q <= syncReady;
			srdySync_q <= srdyMeta_q;
		end
	end
	assign readyNow = ardySync_q | srdySync_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			upperCtrl_q    <= `CSWU_UPPER_RST;
			lowerCtrl_q    <= `CSWU_LOWER_RST;
			midCtrl_q      <= `CSWU_MID_RST;
			pbaseCtrl_q    <= `CSWU_PBASE_RST;
			mpsCtrl_q      <= `CSWU_MPS_RST;
			upperWritten_q <= 1'b0;
			lowerEn_q      <= 1'b0;
			midEn_q        <= 1'b0;
			periphEn_q     <= 1'b0;
		end else begin
			if (upperWr) begin
				upperCtrl_q    <= upperCtrlIn;
				upperWritten_q <= 1'b1;
			end
			if (lowerWr) begin
				lowerCtrl_q <= lowerCtrlIn;
				lowerEn_q   <= 1'b1;
			end
			if (midWr) begin
				midCtrl_q <= midCtrlIn;
				midEn_q   <= 1'b1;
			end
			if (pbaseWr) begin
				pbaseCtrl_q <= pbaseCtrlIn;
				periphEn_q  <= 1'b1;
			end
			if (mpsWr)
				mpsCtrl_q <= mpsCtrlIn;
		end
	end

	// decode of the offered cycle; dma and cpu cycles are treated alike
	assign midMask  = 7'h7f << mpsCtrl_q.midSizeLog;
	assign midShift = cycleIn.addr >> (5'd11 + {2'h0, mpsCtrl_q.midSizeLog});
	assign midIdx   = midShift[1:0];
	assign perIdx   = cycleIn.addr[10:8];
	assign midHit   = midEn_q && !cycleIn.ioSpace &&
		((cycleIn.addr[19:13] & midMask) == (midCtrl_q.base & midMask));
	assign perHit   = periphEn_q && (cycleIn.ioSpace == mpsCtrl_q.ioSpace) &&
		(cycleIn.addr[19:11] == pbaseCtrl_q.base) && (perIdx != 3'h7);
	assign hit[0]   = !cycleIn.ioSpace &&
		regionHit(cycleIn.addr[19:16], upperCtrl_q.sizeLog, 1'b1);
	assign hit[1]   = lowerEn_q && !cycleIn.ioSpace &&
		regionHit(cycleIn.addr[19:16], lowerCtrl_q.sizeLog, 1'b0);
	assign hit[SRC_PCB] = onchipHit;
	assign srcWait[0] = {2'h0, upperCtrl_q.waitCount};
	assign srcRdy[0]  = upperCtrl_q.extReadyRequired;
	assign srcWait[1] = {2'h0, lowerCtrl_q.waitCount};
	assign srcRdy[1]  = lowerCtrl_q.extReadyRequired;
	assign srcWait[SRC_PCB] = 4'h0;
	assign srcRdy[SRC_PCB]  = 1'b0;

	// decode holds whether the pin is a select or pio
	for (genvar i = 0; i < `CSWU_MID_SELECTS; i++) begin : g_mid
		assign hit[SRC_MID+i]     = midHit && (midIdx == 2'(i));
		assign srcWait[SRC_MID+i] = {2'h0, midCtrl_q.waitCount};
		assign srcRdy[SRC_MID+i]  = midCtrl_q.extReadyRequired;
	end
	for (genvar i = 0; i < `CSWU_PERIPH_BLOCKS; i++) begin : g_per
		if (i < 4) begin : g_low
			assign hit[SRC_PER+i]     = perHit && (perIdx == 3'(i));
			assign srcWait[SRC_PER+i] = waitDecode(pbaseCtrl_q.extendedWait,
				pbaseCtrl_q.waitCount);
			assign srcRdy[SRC_PER+i]  = pbaseCtrl_q.extReadyRequired;
		end else begin : g_high
			// block 4 has no pin but keeps its logic; 5 and 6 drop it as latched a1/a2
			assign hit[SRC_PER+i]     = perHit && (perIdx == 3'(i)) &&
				!(i > 4 && mpsCtrl_q.latchedAddress);
			assign srcWait[SRC_PER+i] = {2'h0, mpsCtrl_q.waitCount};
			assign srcRdy[SRC_PER+i]  = mpsCtrl_q.extReadyRequired;
		end
	end

	// overlaps take the strictest setting so a mismatch never ends a cycle early
	always_comb begin
		needRdyD = 1'b0;
		waitsD   = 4'h0;
		for (int i = 0; i < NSRC; i++) begin
			if (hit[i]) begin
				needRdyD = needRdyD | srcRdy[i];
				if (srcWait[i] > waitsD)
					waitsD = srcWait[i];
			end
		end
	end
	assign addrDisD = (hit[0] && upperCtrl_q.addressDriveDisable) ||
		(hit[1] && lowerCtrl_q.addressDriveDisable);

	assign cycleAccept = (state_q == cswu_pkg::ST_IDLE) || (state_q == cswu_pkg::ST_T4);
	assign startCycle  = cycleReq && cycleAccept;
	assign cycleDone   = (state_q == cswu_pkg::ST_T4);
	assign waitActive  = (state_q == cswu_pkg::ST_TW);
	assign busState    = state_q;
	assign waitsDone   = (cnt_q <= 4'h1);

	always_comb begin
		case (state_q)
			cswu_pkg::ST_IDLE: state_d = startCycle ? cswu_pkg::ST_T1 : cswu_pkg::ST_IDLE;
			cswu_pkg::ST_T1:   state_d = cswu_pkg::ST_T2;
			cswu_pkg::ST_T2:   state_d = cswu_pkg::ST_T3;
			cswu_pkg::ST_T3: begin
				if (waits_q != 4'h0 || (needRdy_q && !readyNow))
					state_d = cswu_pkg::ST_TW;
				else
					state_d = cswu_pkg::ST_T4;
			end
			cswu_pkg::ST_TW: begin
				if (pend_q || (first_q && needRdy_q && !readyNow) || !waitsDone)
					state_d = cswu_pkg::ST_TW;
				else
					state_d = cswu_pkg::ST_T4;
			end
			cswu_pkg::ST_T4: state_d = startCycle ? cswu_pkg::ST_T1 : cswu_pkg::ST_IDLE;
			default:         state_d = cswu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= cswu_pkg::ST_IDLE;
			hit_q       <= '0;
			needRdy_q   <= 1'b0;
			waits_q     <= 4'h0;
			addressDriveDisable <= 1'b0;
		end else begin
			state_q <= state_d;
			if (startCycle) begin
				hit_q     <= hit;
				needRdy_q <= needRdyD;
				waits_q   <= waitsD;
				addressDriveDisable <= addrDisD;
			end else if (state_d == cswu_pkg::ST_IDLE) begin
				hit_q <= '0;
				addressDriveDisable <= 1'b0;
			end
		end
	end

	// wait counter: first wait samples ready, a miss parks until ready then adds two
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q       <= 4'h0;
			first_q     <= 1'b0;
			pend_q      <= 1'b0;
			stretched_q <= 1'b0;
		end else if (state_q == cswu_pkg::ST_T3) begin
			cnt_q       <= waits_q;
			first_q     <= (waits_q != 4'h0);
			pend_q      <= (waits_q == 4'h0) && needRdy_q && !readyNow;
			stretched_q <= (waits_q == 4'h0) && needRdy_q && !readyNow;
		end else if (state_q == cswu_pkg::ST_TW) begin
			first_q <= 1'b0;
			if (pend_q) begin
				if (readyNow) begin
					pend_q <= 1'b0;
					cnt_q  <= `CSWU_POST_READY;
				end
			end else if (first_q && needRdy_q && !readyNow) begin
				pend_q      <= 1'b1;
				stretched_q <= 1'b1;
			end else if (!waitsDone) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cycCnt_q <= 5'h00;
		else if (state_d == cswu_pkg::ST_T1)
			cycCnt_q <= 5'h00;
		else if (cycCnt_q != 5'h1f)
			cycCnt_q <= cycCnt_q + 5'h01;
	end

	// upper/lower follow the held address from t1; mid and peripheral follow ad from t2
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			upperSelect_n      <= 1'b1;
			lowerSelect_n      <= 1'b1;
			midSelect_n        <= 4'hf;
			periphSelectLow_n  <= 4'hf;
			periphSelectNext_n <= 1'b1;
			periphSelectTop_n  <= 1'b1;
		end else begin
			// low from the accepting edge through t4, so the far side sees the whole cycle
			upperSelect_n <= !(startCycle ? hit[0] :
				(hit_q[0] && state_d != cswu_pkg::ST_IDLE));
			lowerSelect_n <= !(startCycle ? hit[1] :
				(hit_q[1] && state_d != cswu_pkg::ST_IDLE));
			if (state_q == cswu_pkg::ST_T1) begin
				midSelect_n       <= ~hit_q[SRC_MID+3:SRC_MID];
				periphSelectLow_n <= ~hit_q[SRC_PER+3:SRC_PER];
			end else if (state_d == cswu_pkg::ST_IDLE || state_d == cswu_pkg::ST_T1) begin
				midSelect_n       <= 4'hf;
				periphSelectLow_n <= 4'hf;
			end
			if (mpsCtrl_q.latchedAddress) begin
				periphSelectNext_n <= cycleIn.addr[1];
				periphSelectTop_n  <= cycleIn.addr[2];
			end else if (state_q == cswu_pkg::ST_T1) begin
				periphSelectNext_n <= !hit_q[SRC_PER+5];
				periphSelectTop_n  <= !hit_q[SRC_PER+6];
			end else if (state_d == cswu_pkg::ST_IDLE || state_d == cswu_pkg::ST_T1) begin
				periphSelectNext_n <= 1'b1;
				periphSelectTop_n  <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_park_release;
		pend_q && readyNow && (state_q == cswu_pkg::ST_TW);
	endsequence
	sequence s_two_more_then_end;
		(state_q == cswu_pkg::ST_TW) ##1 (state_q == cswu_pkg::ST_TW) ##1
			(state_q == cswu_pkg::ST_T4);
	endsequence

	chk_boot_upper_hit: assert property (startCycle && !upperWritten_q &&
		cycleIn.addr[19:16] == 4'hf && !cycleIn.ioSpace |=> !upperSelect_n && waits_q == 4'h3
		&& needRdy_q) else $error("boot fetch missed upper select");
	chk_lower_off_reset: assert property (!lowerEn_q |-> lowerSelect_n)
		else $error("lower select active before programming");
	chk_exact_no_ready: assert property (cycleDone && !needRdy_q |->
		cycCnt_q == {1'b0, waits_q} + 5'h3) else $error("access length wrong");
	chk_ready_first_len: assert property (cycleDone && needRdy_q && !stretched_q |->
		cycCnt_q == {1'b0, waits_q} + 5'h3) else $error("ready access length wrong");
	chk_stretch_two_waits: assert property (s_park_release |=> s_two_more_then_end)
		else $error("stretch did not add two waits");
	chk_waits_before_end: assert property (cycleDone |-> cycCnt_q >= {1'b0, waits_q} + 5'h3)
		else $error("cycle ended before programmed waits");
	chk_idle_selects_high: assert property (state_q == cswu_pkg::ST_IDLE && $past(state_q) ==
		cswu_pkg::ST_IDLE |-> upperSelect_n && lowerSelect_n && &midSelect_n &&
		&periphSelectLow_n) else $error("select active outside a cycle");
	chk_addr_disable_hit: assert property (startCycle && hit[0] &&
		upperCtrl_q.addressDriveDisable |=> addressDriveDisable [*3])
		else $error("address drive not suppressed");
	chk_latched_no_wait: assert property (mpsCtrl_q.latchedAddress |->
		!hit[SRC_PER+5] && !hit[SRC_PER+6]) else $error("latched pins kept wait logic");
	chk_mid_late_assert: assert property ($fell(midSelect_n[0]) |->
		$past(state_q) == cswu_pkg::ST_T1) else $error("mid select not in step with ad");
	chk_pcb_no_wait: assert property (startCycle && hit == (NSRC'(1) << SRC_PCB) |=>
		waits_q == 4'h0 && !needRdy_q) else $error("on-chip access given waits");
endmodule
`default_nettype wire

/* File: tb/cswu_ready_model.sv */
// behavioural external memory or peripheral answering on the two ready pins
// assumes the unit's active-low selects and a strobe high in t1 of every bus cycle
`timescale 1ns/1ps
`default_nettype none
module cswu_ready_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       selected,
	input  wire logic       busStart,
	input  wire logic       useSync,
	input  wire logic       slow,
	input  wire logic [3:0] delay,
	output logic            asyncReady,
	output logic            syncReady
);
	logic [3:0] cnt_q;
	logic       rdy;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cnt_q <= 4'h0;
		else if (!selected || busStart)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'hf)
			cnt_q <= cnt_q + 4'h1;
	end
	// a slow device answers delay cycles after t2; the released pin idles low (pull-down)
	assign rdy = !slow || (selected && !busStart && cnt_q >= delay);
	assign syncReady = useSync & rdy;
	// moves off the clock edge, so the unit has to synchronise it
	assign #13 asyncReady = !useSync & rdy;
endmodule
`default_nettype wire

/* File: tb/tb_chip_select_wait_state_unit.sv */
// self-checking bench of the chip-select and wait-state unit
// assumes the package, the unit and the ready model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_chip_select_wait_state_unit;
	logic                       clk_sys = 1'b0;
	logic                       reset_n = 1'b0;
	logic                       cycleReq = 1'b0;
	cswu_pkg::cswu_cycle_s      cycleIn = '0;
	logic                       onchipHit = 1'b0;
	logic [4:0]                 wrs = 5'h00;
	cswu_pkg::cswu_mem_ctrl_s   upperCtrlIn = '0;
	cswu_pkg::cswu_mem_ctrl_s   lowerCtrlIn = '0;
	cswu_pkg::cswu_mid_ctrl_s   midCtrlIn = '0;
	cswu_pkg::cswu_pbase_ctrl_s pbaseCtrlIn = '0;
	cswu_pkg::cswu_mps_ctrl_s   mpsCtrlIn = '0;
	logic                       useSync = 1'b0;
	logic                       slow = 1'b0;
	logic [3:0]                 delay = 4'h8;
	logic                       cycleAccept, cycleDone, waitActive, addressDriveDisable;
	logic                       asyncReady, syncReady, upperSelect_n, lowerSelect_n;
	logic                       periphSelectNext_n, periphSelectTop_n;
	logic [3:0]                 midSelect_n, periphSelectLow_n;
	cswu_pkg::cswu_state_e      busState;
	int                         n_fail = 0;
	int                         total_checks = 0;
	int                         n, k, w, lw, nw;
	logic [19:0]                a;
	wire [11:0] sel = {upperSelect_n, lowerSelect_n, midSelect_n, periphSelectLow_n,
		periphSelectNext_n, periphSelectTop_n};

	always #25 clk_sys = ~clk_sys;

	cswu_unit uut (.clk_sys(clk_sys), .reset_n(reset_n), .cycleReq(cycleReq),
		.cycleIn(cycleIn), .cycleAccept(cycleAccept), .cycleDone(cycleDone),
		.waitActive(waitActive), .asyncReady(asyncReady), .syncReady(syncReady),
		.onchipHit(onchipHit), .upperWr(wrs[4]), .upperCtrlIn(upperCtrlIn),
		.lowerWr(wrs[3]), .lowerCtrlIn(lowerCtrlIn), .midWr(wrs[2]), .midCtrlIn(midCtrlIn),
		.pbaseWr(wrs[1]), .pbaseCtrlIn(pbaseCtrlIn), .mpsWr(wrs[0]), .mpsCtrlIn(mpsCtrlIn),
		.busState(busState), .addressDriveDisable(addressDriveDisable),
		.upperSelect_n(upperSelect_n), .lowerSelect_n(lowerSelect_n),
		.midSelect_n(midSelect_n), .periphSelectLow_n(periphSelectLow_n),
		.periphSelectNext_n(periphSelectNext_n), .periphSelectTop_n(periphSelectTop_n));

	cswu_ready_model partner (.clk_sys(clk_sys), .reset_n(reset_n), .selected(~&sel),
		.busStart(busState == cswu_pkg::ST_T1), .useSync(useSync), .slow(slow),
		.delay(delay), .asyncReady(asyncReady), .syncReady(syncReady));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [11:0] hit(input int pos);
		return 12'hfff & ~(12'h001 << pos);
	endfunction

	function automatic int pwait(input logic e, input logic [1:0] wc);
		int xw[4] = '{5, 7, 9, 15};
		return e ? xw[wc] : int'(wc);
	endfunction

	// a second edge passes before the strobes can rise again
	task automatic wr(input logic [4:0] which);
		wrs = which;
		@(negedge clk_sys);
		wrs = 5'h00;
		@(negedge clk_sys);
	endtask

	// offers one cycle at a falling edge, follows it to t4; n counts cycles after acceptance
	task automatic run(input logic [19:0] ad, input logic io, input logic oc,
		input logic [11:0] es, input logic eda);
		cycleIn = '{addr: ad, ioSpace: io, fromDma: 1'($urandom)};
		onchipHit = oc;
		cycleReq = 1'b1;
		@(negedge clk_sys);
		cycleReq = 1'b0;
		n = 1;
		k = -1;
		nw = 0;
		chk("t1 selects", {upperSelect_n, lowerSelect_n}, es[11:10]);
		while (cycleDone !== 1'b1) begin
			if (busState === cswu_pkg::ST_T3) begin
				chk("selects", sel, es);
				chk("addr disable", addressDriveDisable, eda);
			end
			if (waitActive === 1'b1)
				nw++;
			@(negedge clk_sys);
			n++;
			if (k < 0 && (asyncReady | syncReady))
				k = n;
			if (n > 60) begin
				n_fail++;
				stop_test();
			end
		end
		chk("wait cycles", nw, n - 4);
	endtask

	initial begin
		void'($urandom(32'h0d391d88));
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		chk("reset selects", sel, 12'hfff);
		chk("reset accept", cycleAccept, 1'b1);
		run(20'hffff0, 1'b0, 1'b0, hit(11), 1'b0);
		chk("fetch length", n, 7);
		run(20'hf0000 | 20'($urandom_range(16'hffff)), 1'b0, 1'b0, hit(11), 1'b0);
		chk("upper length", n, 7);
		run(20'hef000 | 20'($urandom_range(12'hfff)), 1'b0, 1'b0, 12'hfff, 1'b0);
		chk("miss length", n, 4);
		$display("test reset and fetch done");
		slow = 1'b1;
		for (int p = 0; p < 2; p++) begin
			useSync = p[0];
			delay = 4'($urandom_range(12, 6));
			run(20'hf0000 | 20'($urandom_range(16'hffff)), 1'b0, 1'b0, hit(11), 1'b0);
			chk("stretched length", n, k + 5);
		end
		$display("test ready stretch done");
		// ready comes far too late here, so waiting on it would show
		delay = 4'hf;
		for (int i = 0; i < 4; i++) begin
			lw = (i < 2) ? 3 * i : $urandom_range(3);
			lowerCtrlIn = '{sizeLog: 3'h0, addressDriveDisable: 1'b1,
				extReadyRequired: 1'b0, waitCount: 2'(lw)};
			wr(5'h08);
			run(20'($urandom_range(16'hffff)), 1'b0, 1'b0, hit(10), 1'b1);
			chk("lower length", n, 4 + lw);
		end
		$display("test lower select done");
		wr(5'h01);
		for (int c = 0; c < 8; c++) begin
			int b;
			b = $urandom_range(3);
			pbaseCtrlIn = '{base: 9'h040, extendedWait: c[2], extReadyRequired: 1'b0,
				waitCount: c[1:0]};
			wr(5'h02);
			run(20'h20000 + 20'(b * 256) + 20'($urandom_range(255)), 1'b0, 1'b0, hit(2 + b),
				1'b0);
			chk("periph length", n, 4 + pwait(c[2], c[1:0]));
		end
		w = $urandom_range(3);
		mpsCtrlIn = '{midSizeLog: 3'h0, ioSpace: 1'b0, latchedAddress: 1'b0,
			extReadyRequired: 1'b0, waitCount: 2'(w)};
		wr(5'h01);
		for (int b = 4; b < 7; b++) begin
			run(20'h20000 + 20'(b * 256), 1'b0, 1'b0, (b == 4) ? 12'hfff : hit(6 - b), 1'b0);
			chk("high periph length", n, 4 + w);
		end
		mpsCtrlIn.latchedAddress = 1'b1;
		mpsCtrlIn.waitCount = 2'h3;
		wr(5'h01);
		a = 20'h20500 | 20'($urandom_range(7));
		run(a, 1'b0, 1'b0, {10'h3ff, a[1], a[2]}, 1'b0);
		chk("latched length", n, 4);
		$display("test peripheral selects done");
		mpsCtrlIn = '{midSizeLog: 3'h0, ioSpace: 1'b1, latchedAddress: 1'b0,
			extReadyRequired: 1'b0, waitCount: 2'h1};
		pbaseCtrlIn = '{base: 9'h000, extendedWait: 1'b0, extReadyRequired: 1'b0,
			waitCount: 2'h2};
		wr(5'h03);
		run(20'h00010, 1'b0, 1'b0, hit(10), 1'b1);
		chk("memory at zero", n, 4 + lw);
		run(20'h00010, 1'b1, 1'b0, hit(2), 1'b0);
		chk("io at zero", n, 6);
		$display("test io space done");
		// moved off the lower region, so no memory regions overlap
		pbaseCtrlIn.base = 9'h040;
		mpsCtrlIn.ioSpace = 1'b0;
		w = $urandom_range(3);
		midCtrlIn = '{base: 7'h20, extReadyRequired: 1'b0, waitCount: 2'(w)};
		wr(5'h07);
		for (int j = 0; j < 4; j++) begin
			run(20'h40000 + 20'(j * 2048) + 20'($urandom_range(2047)), 1'b0, 1'b0,
				hit(6 + j), 1'b0);
			chk("mid length", n, 4 + w);
		end
		run(20'h80000, 1'b0, 1'b1, 12'hfff, 1'b0);
		chk("onchip length", n, 4);
		upperCtrlIn = '{sizeLog: 3'h1, addressDriveDisable: 1'b1, extReadyRequired: 1'b0,
			waitCount: 2'h1};
		wr(5'h10);
		run(20'he0000 | 20'($urandom_range(16'hffff)), 1'b0, 1'b0, hit(11), 1'b1);
		chk("upper resized length", n, 5);
		$display("test mid, onchip and upper done");
		// reset in mid-run must bring back the boot defaults
		slow = 1'b0;
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		chk("rerun selects", sel, 12'hfff);
		run(20'h00010, 1'b0, 1'b0, 12'hfff, 1'b0);
		chk("lower after reset", n, 4);
		run(20'hffff0, 1'b0, 1'b0, hit(11), 1'b0);
		chk("refetch length", n, 7);
		$display("test second reset done");
		stop_test();
	end
endmodule
`default_nettype wire
